// ### rtl/mpw_access_ctrl.sv
/*
 * Request decoder giving a bus master 16-bit or 32-bit access to drive parameters.
 * Assumes a framer feeding checked request bytes without CRC, a framer taking answer
 * bytes and appending CRC, and a parameter store answering one cycle after its enable.
 */
// Notes on behaviour
// [R1] start address bit 15 picks 32-bit access; bits 14..0 address the parameter
// [R2] in 32-bit access the register count must be even, else an exception
// [R3] a 32-bit read returns each parameter as two register slots
// [R4] master sends slave, 0x03, start address, register count, then CRC
// [R5] read answer echoes slave and command, gives byte count, then data
// [R6] a read that cannot be served gets the exception frame instead
// [R7] 16-bit read of a 32-bit parameter returns only its low half
// [R8] 32-bit read of a 16-bit parameter sign-extends only signed ones
// [R9] matching widths return the stored value untouched
// [R10] each parameter is classed signed or unsigned for extension
// [R11] master should read 16-bit only for values in signed 16-bit range
// [R12] 32-bit values go upper word first, each word high byte first
// [R13] single writes 0x06 and 0x41 refuse 32-bit access with an address error
// [R14] 16-bit write into signed 32-bit parameter is sign-extended, store checks range
// [R15] multiple writes 0x10 and 0x43 accept both widths by the same bit
`timescale 1ns/1ps
module mpw_access_ctrl import mpw_pkg::*; #(
	parameter int          AW       = 8,
	parameter logic [15:0] MAX_REGS = MPW_MAX_REGS
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  own_addr,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_last,
	output logic             rx_ready,
	output logic             tx_valid,
	output logic [7:0]       tx_byte,
	output logic             tx_last,
	input  wire logic        tx_ready,
	output logic             prm_rd_en,
	output logic             prm_wr_en,
	output logic [14:0]      prm_addr,
	output logic [31:0]      prm_wr_data,
	input  wire logic [31:0] prm_rd_data,
	input  wire logic        prm_is32,
	input  wire logic        prm_signed,
	input  wire logic        prm_err
);
	mpw_state_t     state_r, after_r;
	logic [7:0]     hdr_r [MPW_HDR_LEN];
	logic [AW:0]    len_r;
	logic           ovf_r, phase_r, wt_r, end_r, is32_r, sgn_r;
	logic [15:0]    j_r;
	logic [AW-1:0]  ptr_r;
	logic [2:0]     k_r, out_n_r;
	logic [31:0]    wd_r;
	logic [47:0]    out_sh_r;
	logic           rx_ready_r, tx_valid_r, tx_last_r, rd_en_r, wr_en_r;
	logic [7:0]     tx_byte_r;
	logic [14:0]    addr_r;
	logic [31:0]    wdata_r;
	logic [7:0]     mem_q;

	// request decode
	wire        rx_take = rx_valid & rx_ready_r;
	wire [7:0]  cmd     = hdr_r[MPW_IDX_CMD];
	wire [15:0] saddr   = {hdr_r[MPW_IDX_AHI], hdr_r[MPW_IDX_ALO]};
	wire [15:0] cnt     = {hdr_r[MPW_IDX_CHI], hdr_r[MPW_IDX_CLO]};
	wire [7:0]  bcnt    = hdr_r[MPW_IDX_BCNT];
	wire        wide    = saddr[MPW_WIDE_BIT];                           // [R1]
	wire [14:0] base    = saddr[14:0];                                   // [R1]
	wire        is_rd   = cmd == MPW_CMD_READ;                           // [R4]
	wire        is_wr1  = (cmd == MPW_CMD_WR1) | (cmd == MPW_CMD_WR1X);
	wire        is_wrn  = (cmd == MPW_CMD_WRN) | (cmd == MPW_CMD_WRNX);  // [R15]
	wire        cnt_bad = (cnt == 16'h0000) | (cnt > MAX_REGS) | (wide & cnt[0]); // [R2]
	wire [8:0]  wrn_len = MPW_LEN_WRN + {1'b0, bcnt};
	wire        len_bad = is_wrn ? ({{(8 - AW){1'b0}}, len_r} != wrn_len)
	                              | ({8'h00, bcnt} != {cnt[14:0], 1'b0})
	                             : ({{(8 - AW){1'b0}}, len_r} != MPW_LEN_FIXED);
	wire [7:0]  exc     = !(is_rd | is_wr1 | is_wrn) ? MPW_EXC_FUNC :
	                      (is_wr1 & wide) ? MPW_EXC_ADDR :               // [R13]
	                      ((is_rd | is_wrn) & cnt_bad) ? MPW_EXC_VALUE : // [R2]
	                      len_bad ? MPW_EXC_VALUE : MPW_EXC_NONE;
	wire [15:0] np      = is_wr1 ? 16'h0001 : (wide ? {1'b0, cnt[15:1]} : cnt);
	wire        last_j  = j_r == (np - 16'h0001);
	wire [14:0] cur     = base + j_r[14:0];
	wire        wide_wr = wide & is_wrn;                                 // [R15]
	wire [2:0]  need    = wide_wr ? MPW_N_W32 : MPW_N_W16;

	// width adaption on read
	wire        rd_ext  = prm_signed & prm_rd_data[15];                  // [R8] [R10]
	wire [31:0] rd_w32  = prm_is32 ? prm_rd_data                        // [R9]
	                               : {{16{rd_ext}}, prm_rd_data[15:0]};  // [R8]
	wire [15:0] rd_w16  = prm_rd_data[15:0];                             // [R7] [R9]
	wire [47:0] rd_sh   = wide ? {rd_w32, 16'h0000}                     // [R3] [R12]
	                           : {rd_w16, 32'h0000_0000};
	wire [47:0] rhdr_sh = {hdr_r[MPW_IDX_SLAVE], cmd, cnt[6:0], 1'b0, 24'h000000}; // [R5]

	// width adaption on write
	wire        wr_ext  = sgn_r & is32_r & wd_r[15];                     // [R14]
	wire [31:0] wval    = wide_wr ? wd_r : {{16{wr_ext}}, wd_r[15:0]};   // [R14]
	wire [47:0] echo_sh = {hdr_r[0], hdr_r[1], hdr_r[2], hdr_r[3], hdr_r[4], hdr_r[5]};

	wire        tx_free = !tx_valid_r | tx_ready;

	function automatic logic [47:0] exc_frame(input logic [7:0] s, input logic [7:0] c, input logic [7:0] code);
		exc_frame = {s, c | MPW_EXC_FLAG, code, 24'h000000};
	endfunction

	mpw_frame_mem #(.AW(AW)) u_mem (
		.clock   (clock),
		.reset_n (reset_n),
		.wr_en   (rx_take & !len_r[AW]),
		.wr_addr (len_r[AW-1:0]),
		.wr_data (rx_byte),
		.rd_addr (ptr_r),
		.rd_data (mem_q)
	);

	// header bytes kept in flops, the rest only in the frame memory
	for (genvar i = 0; i < MPW_HDR_LEN; i++) begin : g_hdr
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				hdr_r[i] <= 8'h00;
			end else if (rx_take && len_r == (AW + 1)'(i)) begin
				hdr_r[i] <= rx_byte;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= MPW_ST_IDLE;
			after_r    <= MPW_ST_IDLE;
			len_r      <= '0;
			ovf_r      <= 1'b0;
			phase_r    <= 1'b0;
			wt_r       <= 1'b0;
			end_r      <= 1'b0;
			is32_r     <= 1'b0;
			sgn_r      <= 1'b0;
			j_r        <= 16'h0000;
			ptr_r      <= '0;
			k_r        <= 3'd0;
			wd_r       <= 32'h0000_0000;
			out_sh_r   <= 48'h0;
			out_n_r    <= 3'd0;
			rx_ready_r <= 1'b1;
			tx_valid_r <= 1'b0;
			tx_last_r  <= 1'b0;
			tx_byte_r  <= 8'h00;
			rd_en_r    <= 1'b0;
			wr_en_r    <= 1'b0;
			addr_r     <= 15'h0000;
			wdata_r    <= 32'h0000_0000;
		end else begin
			rd_en_r <= 1'b0;
			wr_en_r <= 1'b0;
			unique case (state_r)
			MPW_ST_IDLE: begin
				if (rx_take) begin
					// overlong frames are dropped rather than wrapped into the header
					if (len_r[AW]) begin
						ovf_r <= 1'b1;
					end else begin
						len_r <= len_r + 1'b1;
					end
					if (rx_last) begin
						rx_ready_r <= 1'b0;
						state_r    <= MPW_ST_CHECK;
					end
				end
			end
			MPW_ST_CHECK: begin
				len_r   <= '0;
				ovf_r   <= 1'b0;
				j_r     <= 16'h0000;
				phase_r <= 1'b0;
				wt_r    <= 1'b0;
				ptr_r   <= is_wr1 ? MPW_PTR_WR1[AW-1:0] : MPW_PTR_WRN[AW-1:0];
				if (ovf_r || hdr_r[MPW_IDX_SLAVE] != own_addr) begin
					rx_ready_r <= 1'b1;
					state_r    <= MPW_ST_IDLE;
				end else if (exc != MPW_EXC_NONE) begin
					out_sh_r <= exc_frame(hdr_r[MPW_IDX_SLAVE], cmd, exc); // [R6] [R13] [R2]
					out_n_r  <= MPW_N_EXC;
					end_r    <= 1'b1;
					after_r  <= MPW_ST_IDLE;
					state_r  <= MPW_ST_SEND;
				end else begin
					state_r <= MPW_ST_PROBE;
				end
			end
			MPW_ST_PROBE: begin
				rd_en_r <= 1'b1;
				addr_r  <= cur;
				state_r <= MPW_ST_PWAIT;
			end
			MPW_ST_PWAIT: begin
				wt_r <= !wt_r;
				if (wt_r) begin
					if (prm_err) begin
						// reads are probed in full before any data leaves
						out_sh_r <= exc_frame(hdr_r[MPW_IDX_SLAVE], cmd, MPW_EXC_ADDR); // [R6]
						out_n_r  <= MPW_N_EXC;
						end_r    <= 1'b1;
						after_r  <= MPW_ST_IDLE;
						state_r  <= MPW_ST_SEND;
					end else if (is_rd && !phase_r) begin
						if (last_j) begin
							phase_r  <= 1'b1;
							j_r      <= 16'h0000;
							out_sh_r <= rhdr_sh; // [R5]
							out_n_r  <= MPW_N_RHDR;
							end_r    <= 1'b0;
							after_r  <= MPW_ST_PROBE;
							state_r  <= MPW_ST_SEND;
						end else begin
							j_r     <= j_r + 16'h0001;
							state_r <= MPW_ST_PROBE;
						end
					end else if (is_rd) begin
						out_sh_r <= rd_sh; // [R3] [R7] [R8] [R9]
						out_n_r  <= wide ? MPW_N_W32 : MPW_N_W16;
						end_r    <= last_j;
						after_r  <= last_j ? MPW_ST_IDLE : MPW_ST_PROBE;
						j_r      <= j_r + 16'h0001;
						state_r  <= MPW_ST_SEND;
					end else begin
						is32_r  <= prm_is32;
						sgn_r   <= prm_signed; // [R10]
						k_r     <= 3'd0;
						wd_r    <= 32'h0000_0000;
						state_r <= MPW_ST_WFETCH;
					end
				end
			end
			MPW_ST_WFETCH: begin
				state_r <= MPW_ST_WSHIFT;
			end
			MPW_ST_WSHIFT: begin
				wd_r    <= {wd_r[23:0], mem_q}; // [R12]
				ptr_r   <= ptr_r + 1'b1;
				k_r     <= k_r + 3'd1;
				state_r <= (k_r == need - 3'd1) ? MPW_ST_WSTORE : MPW_ST_WFETCH;
			end
			MPW_ST_WSTORE: begin
				wr_en_r <= 1'b1;
				addr_r  <= cur;
				wdata_r <= wval; // [R14] [R15]
				state_r <= MPW_ST_WWAIT;
			end
			MPW_ST_WWAIT: begin
				wt_r <= !wt_r;
				if (wt_r) begin
					if (prm_err) begin
						// earlier parameters of this request stay written
						out_sh_r <= exc_frame(hdr_r[MPW_IDX_SLAVE], cmd, MPW_EXC_VALUE); // [R14]
						out_n_r  <= MPW_N_EXC;
						end_r    <= 1'b1;
						after_r  <= MPW_ST_IDLE;
						state_r  <= MPW_ST_SEND;
					end else if (last_j) begin
						out_sh_r <= echo_sh;
						out_n_r  <= MPW_N_ECHO;
						end_r    <= 1'b1;
						after_r  <= MPW_ST_IDLE;
						state_r  <= MPW_ST_SEND;
					end else begin
						j_r     <= j_r + 16'h0001;
						state_r <= MPW_ST_PROBE;
					end
				end
			end
			MPW_ST_SEND: begin
				if (tx_free) begin
					if (out_n_r != 3'd0) begin
						tx_byte_r  <= out_sh_r[47:40]; // [R12]
						out_sh_r   <= {out_sh_r[39:0], 8'h00};
						out_n_r    <= out_n_r - 3'd1;
						tx_valid_r <= 1'b1;
						tx_last_r  <= end_r & (out_n_r == 3'd1);
					end else begin
						tx_valid_r <= 1'b0;
						tx_last_r  <= 1'b0;
						state_r    <= after_r;
						rx_ready_r <= after_r == MPW_ST_IDLE;
					end
				end
			end
			default: begin
				state_r    <= MPW_ST_IDLE;
				rx_ready_r <= 1'b1;
			end
			endcase
		end
	end

	assign rx_ready    = rx_ready_r;
	assign tx_valid    = tx_valid_r;
	assign tx_byte     = tx_byte_r;
	assign tx_last     = tx_last_r;
	assign prm_rd_en   = rd_en_r;
	assign prm_wr_en   = wr_en_r;
	assign prm_addr    = addr_r;
	assign prm_wr_data = wdata_r;
endmodule // mpw_access_ctrl

// ### rtl/mpw_frame_mem.sv
/*
 * Byte memory holding one received request frame.
 * Assumes single clock; read data is registered, one cycle after the address.
 */
`timescale 1ns/1ps
module mpw_frame_mem #(
	parameter int AW = 8
) (
	input  wire logic          clock,
	input  wire logic          reset_n,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	logic [7:0] mem_r [2**AW];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem_r[rd_addr];
		end
	end
endmodule // mpw_frame_mem

// ### shared/mpw_pkg.sv
/*
 * Constants and the state type of the parameter width access decoder.
 * Assumes a framer that strips and checks the CRC before handing bytes over.
 */
package mpw_pkg;

	// function codes
	localparam logic [7:0] MPW_CMD_READ  = 8'h03;
	localparam logic [7:0] MPW_CMD_WR1   = 8'h06;
	localparam logic [7:0] MPW_CMD_WR1X  = 8'h41;
	localparam logic [7:0] MPW_CMD_WRN   = 8'h10;
	localparam logic [7:0] MPW_CMD_WRNX  = 8'h43;

	// exception answer
	localparam logic [7:0] MPW_EXC_FLAG  = 8'h80;
	localparam logic [7:0] MPW_EXC_NONE  = 8'h00;
	localparam logic [7:0] MPW_EXC_FUNC  = 8'h01;
	localparam logic [7:0] MPW_EXC_ADDR  = 8'h02;
	localparam logic [7:0] MPW_EXC_VALUE = 8'h03;

	// start address layout
	localparam int         MPW_WIDE_BIT  = 15;

	// request byte positions, CRC excluded
	localparam int         MPW_IDX_SLAVE = 0;
	localparam int         MPW_IDX_CMD   = 1;
	localparam int         MPW_IDX_AHI   = 2;
	localparam int         MPW_IDX_ALO   = 3;
	localparam int         MPW_IDX_CHI   = 4;
	localparam int         MPW_IDX_CLO   = 5;
	localparam int         MPW_IDX_BCNT  = 6;
	localparam int         MPW_HDR_LEN   = 7;

	// frame lengths and data pointers
	localparam logic [8:0] MPW_LEN_FIXED = 9'd6;
	localparam logic [8:0] MPW_LEN_WRN   = 9'd7;
	localparam logic [7:0] MPW_PTR_WR1   = 8'd4;
	localparam logic [7:0] MPW_PTR_WRN   = 8'd7;
	localparam logic [15:0] MPW_MAX_REGS = 16'd125;

	// answer lengths in bytes
	localparam logic [2:0] MPW_N_EXC     = 3'd3;
	localparam logic [2:0] MPW_N_RHDR    = 3'd3;
	localparam logic [2:0] MPW_N_ECHO    = 3'd6;
	localparam logic [2:0] MPW_N_W16     = 3'd2;
	localparam logic [2:0] MPW_N_W32     = 3'd4;

	typedef enum logic [8:0] {
		MPW_ST_IDLE   = 9'h001,
		MPW_ST_CHECK  = 9'h002,
		MPW_ST_PROBE  = 9'h004,
		MPW_ST_PWAIT  = 9'h008,
		MPW_ST_WFETCH = 9'h010,
		MPW_ST_WSHIFT = 9'h020,
		MPW_ST_WSTORE = 9'h040,
		MPW_ST_WWAIT  = 9'h080,
		MPW_ST_SEND   = 9'h100
	} mpw_state_t;

endpackage

// ### tb/modbus_param_width_access_bench.sv
/*
 * Self-checking bench for the parameter width access decoder.
 * Assumes the store model as far side and slave address 05.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module modbus_param_width_access_bench import mpw_pkg::*;;
	logic        clock, reset_n, rx_valid, rx_last, tx_ready;
	logic [7:0]  rx_byte;
	wire logic   rx_ready, tx_valid, tx_last, prm_rd_en, prm_wr_en, prm_is32, prm_signed, prm_err;
	wire logic [7:0]  tx_byte;
	wire logic [14:0] prm_addr;
	wire logic [31:0] prm_wr_data, prm_rd_data;
	int          err_count, cmp_count;
	integer      seed = 32'h42ea;
	logic [8:0]  exp_q[$];
	logic [8:0]  exp_e;
	logic [7:0]  fr[$];
	logic [31:0] d;

	mpw_access_ctrl u_dut (.clock(clock), .reset_n(reset_n), .own_addr(8'h05), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_last(tx_last), .tx_ready(tx_ready), .prm_rd_en(prm_rd_en), .prm_wr_en(prm_wr_en),
		.prm_addr(prm_addr), .prm_wr_data(prm_wr_data), .prm_rd_data(prm_rd_data), .prm_is32(prm_is32),
		.prm_signed(prm_signed), .prm_err(prm_err));
	mpw_store_model u_store (.clock(clock), .prm_rd_en(prm_rd_en), .prm_wr_en(prm_wr_en),
		.prm_addr(prm_addr), .prm_wr_data(prm_wr_data), .prm_rd_data(prm_rd_data), .prm_is32(prm_is32),
		.prm_signed(prm_signed), .prm_err(prm_err));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic test_done();
		$display("errors %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic push(input logic [7:0] b, input logic l);
		exp_q.push_back({l, b});
	endtask

	task automatic exc(input logic [7:0] c, input logic [7:0] code);
		push(8'h05, 1'b0);
		push(c | MPW_EXC_FLAG, 1'b0);
		push(code, 1'b1);
	endtask

	task automatic echo();
		for (int i = 0; i < 6; i++)
			push(fr[i], i == 5);
	endtask

	// sends fr whole, then waits for the answer to drain and the port to reopen
	task automatic go();
		foreach (fr[i]) begin
			rx_valid <= 1'b1;
			rx_byte <= fr[i];
			rx_last <= (i == fr.size() - 1);
			do @(posedge clock); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		for (int k = 0; k < 3000; k++) begin
			@(posedge clock);
			if (k > 3 && rx_ready === 1'b1 && exp_q.size() == 0)
				break;
		end
	endtask

	task automatic rd(input logic w, input int n);
		logic [31:0] v;
		fr = '{8'h05, MPW_CMD_READ, {w, 7'h00}, 8'h00, 8'h00, 8'(w ? 2 * n : n)};
		push(8'h05, 1'b0);
		push(MPW_CMD_READ, 1'b0);
		push(8'(w ? 4 * n : 2 * n), 1'b0);
		for (int i = 0; i < n; i++) begin
			v = u_store.val[i];
			if (!u_store.is32[i])
				v = {{16{u_store.sgn[i] & v[15]}}, v[15:0]};
			if (w) begin
				push(v[31:24], 1'b0);
				push(v[23:16], 1'b0);
			end
			push(v[15:8], 1'b0);
			push(v[7:0], i == n - 1);
		end
		go();
	endtask

	always @(posedge clock)
		tx_ready <= ($random(seed) & 3) != 0;

	always @(posedge clock)
		if (reset_n === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			exp_e = exp_q.size() ? exp_q.pop_front() : 9'h1ff;
			`CHK({tx_last, tx_byte}, exp_e)
		end

	initial begin
		#250000;
		err_count++;
		test_done();
	end

	initial begin
		reset_n = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_last = 1'b0;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		rd(1'b0, 8);
		rd(1'b1, 8);
		fr = '{8'h05, 8'h03, 8'h80, 8'h00, 8'h00, 8'h03}; exc(8'h03, MPW_EXC_VALUE); go();
		fr = '{8'h05, 8'h03, 8'h00, 8'h08, 8'h00, 8'h01}; exc(8'h03, MPW_EXC_ADDR); go();
		// overlong read, empty read and a multi write whose byte count disagrees with its count
		fr = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00}; exc(8'h03, MPW_EXC_VALUE); go();
		fr = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}; exc(8'h03, MPW_EXC_VALUE); go();
		fr = '{8'h05, 8'h10, 8'h80, 8'h00, 8'h00, 8'h02, 8'h02, 8'h12, 8'h34}; exc(8'h10, MPW_EXC_VALUE); go();
		fr = '{8'h05, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}; exc(8'h07, MPW_EXC_FUNC); go();
		fr = '{8'h05, 8'h06, 8'h80, 8'h01, 8'hfe, 8'h0c}; exc(8'h06, MPW_EXC_ADDR); go();
		fr = '{8'h05, 8'h41, 8'h80, 8'h01, 8'hfe, 8'h0c}; exc(8'h41, MPW_EXC_ADDR); go();
		fr = '{8'h06, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}; go();
		fr = '{8'h05, 8'h06, 8'h00, 8'h01, 8'hfe, 8'h0c}; echo(); go();
		`CHK(u_store.val[1], 32'hfffffe0c)
		fr = '{8'h05, 8'h41, 8'h00, 8'h06, 8'h00, 8'h01}; exc(8'h41, MPW_EXC_VALUE); go();
		d = $random(seed);
		fr = '{8'h05, 8'h10, 8'h80, 8'h03, 8'h00, 8'h02, 8'h04, d[31:24], d[23:16], d[15:8], d[7:0]};
		echo(); go();
		`CHK(u_store.val[3], d)
		fr = '{8'h05, 8'h43, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, d[15:8], d[7:0]}; echo(); go();
		`CHK(u_store.val[0], {16'h0000, d[15:0]})
		rd(1'b1, 6);
		rd(1'b0, 6);
		test_done();
	end
endmodule // modbus_param_width_access_bench

// ### tb/mpw_access_chk.sv
/*
 * Port-level checker for the parameter width access decoder.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module mpw_access_chk import mpw_pkg::*; #(
	parameter int          AW       = 8,
	parameter logic [15:0] MAX_REGS = MPW_MAX_REGS
) (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        rx_valid,
	input wire logic        rx_last,
	input wire logic        rx_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_byte,
	input wire logic        tx_last,
	input wire logic        tx_ready,
	input wire logic        prm_rd_en,
	input wire logic        prm_wr_en,
	input wire logic [14:0] prm_addr,
	input wire logic [31:0] prm_wr_data
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_last_taken;
		rx_valid && rx_ready && rx_last;
	endsequence
	sequence s_tx_stall;
		tx_valid && !tx_ready;
	endsequence

	a_tx_held: assert property (s_tx_stall |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
		else $error("answer byte changed before acceptance");
	a_answer_gap: assert property (s_last_taken |=> !tx_valid [*2])
		else $error("answer started too early");
	a_ready_drop: assert property (s_last_taken |=> !rx_ready)
		else $error("request side still ready after last byte");
	a_busy_ready: assert property (tx_valid |-> !rx_ready)
		else $error("request side ready while answering");
	a_rd_pulse: assert property (prm_rd_en |=> !prm_rd_en)
		else $error("read enable longer than one cycle");
	a_wr_pulse: assert property (prm_wr_en |=> !prm_wr_en)
		else $error("write enable longer than one cycle");
	a_en_excl: assert property (!(prm_rd_en && prm_wr_en))
		else $error("read and write enable together");
	a_wr_hold: assert property (prm_wr_en |=> $stable(prm_addr) && $stable(prm_wr_data))
		else $error("write address or data moved after enable");
endmodule // mpw_access_chk

bind mpw_access_ctrl mpw_access_chk #(.AW(AW), .MAX_REGS(MAX_REGS)) u_chk (
	.clock(clock), .reset_n(reset_n), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
	.tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready), .prm_rd_en(prm_rd_en),
	.prm_wr_en(prm_wr_en), .prm_addr(prm_addr), .prm_wr_data(prm_wr_data)
);

// ### tb/mpw_store_model.sv
/*
 * Behavioural parameter store: eight parameters with width and sign class.
 * Assumes the decoder samples answers in the cycle after each enable pulse.
 */
`timescale 1ns/1ps
module mpw_store_model (
	input  wire logic        clock,
	input  wire logic        prm_rd_en,
	input  wire logic        prm_wr_en,
	input  wire logic [14:0] prm_addr,
	input  wire logic [31:0] prm_wr_data,
	output logic      [31:0] prm_rd_data,
	output logic             prm_is32,
	output logic             prm_signed,
	output logic             prm_err
);
	logic [31:0] val [0:7];
	logic [7:0]  is32 = 8'h3a;
	logic [7:0]  sgn  = 8'h3f;
	wire         miss = prm_addr > 15'h0007;

	initial begin
		val = '{32'h1194, 32'hfe0c, 32'hfe0c, 32'h1388, 32'h186a0, 32'hfffe7960, 32'hffff, 32'h8001};
		prm_rd_data = 32'h0;
		prm_is32 = 1'b0;
		prm_signed = 1'b0;
		prm_err = 1'b0;
	end

	always @(posedge clock) begin
		// stale read data and error toggle so a late sample is caught; width and sign class hold
		prm_rd_data <= ~prm_rd_data;
		prm_err <= ~prm_err;
		if (prm_rd_en) begin
			prm_rd_data <= val[prm_addr[2:0]];
			prm_is32 <= is32[prm_addr[2:0]];
			prm_signed <= sgn[prm_addr[2:0]];
			prm_err <= miss;
		end
		// parameter 6 refuses writes to exercise the range reject
		if (prm_wr_en) begin
			prm_err <= miss || prm_addr == 15'h0006;
			if (!miss && prm_addr != 15'h0006)
				val[prm_addr[2:0]] <= prm_wr_data;
		end
	end
endmodule // mpw_store_model
